/* File: verilog/sti_interlock.sv */
// Torque-off interlock with AHB-Lite register slave
// Overview of operation
// [RL1] Torque-off input de-energised always disables output stage, regardless of settings.
// [RL2] Output stage becomes torque-free within 1 ms of input de-energising.
// [RL3] Torque-off status indication changes within 20 ms of input de-energising.
// [RL4] Channel fault shown on display and health output within 20 ms.
// [RL5] Fault in either internal channel raises trip with code 29.
// [RL6] Energised input: standby; start command from configured source runs the drive.
// [RL7] De-energised input shows inhibit; a present trip is shown instead.
// [RL8] Relay one selector value 13 opens relay one while torque-off active.
// [RL9] Relay two selector value 13 opens relay two while torque-off active.
// [RL10] Edge mode starts only on run rising edge once ready; auto restarts immediately.
// [RL11] Start command while de-energised is ignored; inhibit stays, no torque.
// [RL12] Input synchronised for status; gating path acts directly, unclocked.
//
// Local design decisions: the AHB-Lite interface to the registers and the register offsets.
module sti_interlock
  import sti_pkg::*;
(
  // Clock and reset
  input  wire logic        hclk,
  input  wire logic        hresetn,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Torque-off channels, high when energised
  input  wire logic        torque_ch_a,
  input  wire logic        torque_ch_b,
  // Run commands, one per start source
  input  wire logic [3:0]  run_cmd,
  // Gate request from motor control, gated result to power stage
  input  wire logic        pwm_gate_req,
  output logic             pwm_gate,
  // Drive-facing status
  output sti_out_type      drv_out,
  output logic             irq
);

  sti_ctrl_type ctrl_reg;
  logic [3:0]   irq_st_reg;
  logic [3:0]   irq_msk_reg;
  logic [1:0]   ch_a_sync_reg;
  logic [1:0]   ch_b_sync_reg;
  logic [3:0]   run_sync0_reg;
  logic [3:0]   run_sync1_reg;
  logic         run_prev_reg;
  logic         running_reg;
  logic         armed_reg;
  logic         fault_reg;
  logic [22:0]  disagree_cnt_reg;
  logic         sto_active_prev_reg;
  logic         wr_pend_reg;
  logic [7:0]   addr_reg;
  logic         clr_fault_req;
  logic         sto_active;
  logic         run_sel;
  logic         start_ok;
  logic [3:0]   irq_event;
  logic         addr_ok;
  logic         rd_wait_reg;
  logic [31:0]  rd_mux;

  // Status bits that a write-one-clear word hits
  function automatic logic [3:0] w1c_mask(input logic [31:0] w);
    return w[3:0];
  endfunction : w1c_mask

  // Data phase of a write to the given offset
  function automatic logic reg_wr_hit(input logic       pend,
                                      input logic [7:0] addr,
                                      input logic [7:0] ofs);
    return pend && addr == ofs;
  endfunction : reg_wr_hit

  // Relay opens while torque-off is active and its selector asks for it
  function automatic logic relay_open(input logic       active,
                                      input logic [7:0] fn_sel);
    return active && fn_sel == RELAY_FN_TORQUE_OFF;
  endfunction : relay_open

  // Direct combinational gate path, no clocked delay
  assign pwm_gate = pwm_gate_req & running_reg & torque_ch_a & torque_ch_b; // see [RL1] [RL2] [RL12]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ch_a_sync_reg <= 2'h0;
      ch_b_sync_reg <= 2'h0;
      run_sync0_reg <= 4'h0;
      run_sync1_reg <= 4'h0;
    end
    else
    begin
      ch_a_sync_reg <= {ch_a_sync_reg[0], torque_ch_a}; // see [RL12]
      ch_b_sync_reg <= {ch_b_sync_reg[0], torque_ch_b};
      run_sync0_reg <= run_cmd;
      run_sync1_reg <= run_sync0_reg;
    end
  end

  // Active when either channel is de-energised
  assign sto_active = !(ch_a_sync_reg[1] & ch_b_sync_reg[1]); // see [RL3]
  assign run_sel    = run_sync1_reg[ctrl_reg.start_source_select[1:0]]; // see [RL6]

  // Channel disagreement supervision
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      disagree_cnt_reg <= 23'h000000;
      fault_reg        <= 1'b0;
    end
    else
    begin
      if (ch_a_sync_reg[1] != ch_b_sync_reg[1])
      begin
        if (disagree_cnt_reg != DISAGREE_CYC[22:0])
          disagree_cnt_reg <= disagree_cnt_reg + 23'h000001;
      end
      else
        disagree_cnt_reg <= 23'h000000;
      if (disagree_cnt_reg == DISAGREE_CYC[22:0])
        fault_reg <= 1'b1; // see [RL5]
      else if (clr_fault_req)
        fault_reg <= 1'b0;
    end
  end

  // Edge mode needs a fresh rising run edge once ready
  assign start_ok = ctrl_reg.start_mode_select ? (run_sel & !run_prev_reg & armed_reg)
                                               : run_sel; // see [RL10]

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      running_reg  <= 1'b0;
      run_prev_reg <= 1'b0;
      armed_reg    <= 1'b0;
    end
    else
    begin
      run_prev_reg <= run_sel;
      armed_reg    <= !sto_active & !fault_reg;
      if (sto_active | fault_reg | !run_sel)
        running_reg <= 1'b0; // see [RL1] [RL11]
      else if (start_ok)
        running_reg <= 1'b1; // see [RL6]
    end
  end

  // Drive-facing outputs, registered
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      drv_out <= '{run_enable: 1'b0, relay_one_closed: 1'b0, relay_two_closed: 1'b0,
                   healthy: 1'b0, disp: DISP_STOP, trip_code: TRIP_CODE_NONE};
    end
    else
    begin
      drv_out.run_enable <= running_reg;
      drv_out.relay_one_closed <= !relay_open(sto_active,
                                              ctrl_reg.relay_one_function_select); // see [RL8]
      drv_out.relay_two_closed <= !relay_open(sto_active,
                                              ctrl_reg.relay_two_function_select); // see [RL9]
      drv_out.healthy   <= !fault_reg; // see [RL4]
      drv_out.trip_code <= fault_reg ? TRIP_CODE_CHANNEL : TRIP_CODE_NONE; // see [RL5]
      if (fault_reg)
        drv_out.disp <= DISP_TRIP; // see [RL4] [RL7]
      else if (sto_active)
        drv_out.disp <= DISP_INHIBIT; // see [RL7] [RL11]
      else if (running_reg)
        drv_out.disp <= DISP_RUN;
      else
        drv_out.disp <= DISP_STOP;
    end
  end

  // Interrupt events
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      sto_active_prev_reg <= 1'b1;
    else
      sto_active_prev_reg <= sto_active;
  end

  assign irq_event[IRQ_INHIBIT] = sto_active & !sto_active_prev_reg;
  assign irq_event[IRQ_RELEASE] = !sto_active & sto_active_prev_reg;
  assign irq_event[IRQ_FAULT]   = (disagree_cnt_reg == DISAGREE_CYC[22:0]) & !fault_reg;
  assign irq_event[IRQ_START]   = start_ok & !running_reg & !sto_active & !fault_reg;
  assign irq = |(irq_st_reg & irq_msk_reg);

  // AHB-Lite address phase capture; writes land at the end of their data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_pend_reg <= 1'b0;
      addr_reg    <= 8'h00;
    end
    else if (hready)
    begin
      wr_pend_reg <= hsel & htrans[1] & hwrite;
      addr_reg    <= haddr[7:0];
    end
  end

  assign clr_fault_req = reg_wr_hit(wr_pend_reg, addr_reg, OFS_CTRL) && hwdata[CTRL_CLR_BIT];

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_reg.relay_one_function_select <= CTRL_RESET[CTRL_RLY1_LSB +: 8];
      ctrl_reg.relay_two_function_select <= CTRL_RESET[CTRL_RLY2_LSB +: 8];
      ctrl_reg.start_mode_select         <= CTRL_RESET[CTRL_EDGE_BIT];
      ctrl_reg.start_source_select       <= CTRL_RESET[CTRL_SRC_LSB +: 4];
    end
    else if (reg_wr_hit(wr_pend_reg, addr_reg, OFS_CTRL))
    begin
      ctrl_reg.relay_one_function_select <= hwdata[CTRL_RLY1_LSB +: 8];
      ctrl_reg.relay_two_function_select <= hwdata[CTRL_RLY2_LSB +: 8];
      ctrl_reg.start_mode_select         <= hwdata[CTRL_EDGE_BIT];
      ctrl_reg.start_source_select       <= hwdata[CTRL_SRC_LSB +: 4];
    end
  end

  // Sticky status, set wins over write-one clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      irq_st_reg  <= 4'h0;
      irq_msk_reg <= MASK_RESET;
    end
    else
    begin
      if (reg_wr_hit(wr_pend_reg, addr_reg, OFS_IRQ_ST))
        irq_st_reg <= (irq_st_reg & ~w1c_mask(hwdata)) | irq_event;
      else
        irq_st_reg <= irq_st_reg | irq_event;
      if (reg_wr_hit(wr_pend_reg, addr_reg, OFS_IRQ_MSK))
        irq_msk_reg <= hwdata[3:0];
    end
  end

  assign addr_ok = addr_reg == OFS_CTRL || addr_reg == OFS_STATUS ||
                   addr_reg == OFS_IRQ_ST || addr_reg == OFS_IRQ_MSK;

  // Read mux over the offset held from the address phase
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (addr_ok)
    begin
      unique case (addr_reg)
        OFS_CTRL:
        begin
          rd_mux[CTRL_RLY1_LSB +: 8] = ctrl_reg.relay_one_function_select;
          rd_mux[CTRL_RLY2_LSB +: 8] = ctrl_reg.relay_two_function_select;
          rd_mux[CTRL_EDGE_BIT]      = ctrl_reg.start_mode_select;
          rd_mux[CTRL_SRC_LSB +: 4]  = ctrl_reg.start_source_select;
        end
        OFS_STATUS:
          rd_mux = {16'h0000, drv_out.trip_code, 2'h0, fault_reg, running_reg,
                    ch_b_sync_reg[1], ch_a_sync_reg[1], sto_active, irq};
        OFS_IRQ_ST:  rd_mux[3:0] = irq_st_reg;
        OFS_IRQ_MSK: rd_mux[3:0] = irq_msk_reg;
      endcase
    end
  end

  // Reads take one wait state so read data leave a flip-flop and see prior writes
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rd_wait_reg <= 1'b0;
      hrdata      <= 32'h0000_0000;
    end
    else
    begin
      rd_wait_reg <= hready & hsel & htrans[1] & !hwrite;
      if (rd_wait_reg)
        hrdata <= rd_mux;
    end
  end

  // Always OKAY; ready drops only in the first cycle of a read data phase
  assign hreadyout = !rd_wait_reg;
  assign hresp     = 1'b0;

endmodule : sti_interlock

/* File: common/sti_pkg.sv */
// Package for the torque-off interlock: register map, fields, codes, timing
package sti_pkg;

  // Clock and timing
  localparam int unsigned CLK_HZ          = 20_000_000;
  localparam int unsigned GATE_LIMIT_US   = 1000;
  localparam int unsigned STATUS_LIMIT_MS = 20;
  localparam int unsigned FAULT_LIMIT_MS  = 20;
  // Channel disagreement must persist this long before it is a fault
  localparam int unsigned DISAGREE_US     = 200;
  localparam int unsigned DISAGREE_CYC    = DISAGREE_US * (CLK_HZ / 1_000_000);
  localparam int unsigned STATUS_LIMIT_CYC = STATUS_LIMIT_MS * (CLK_HZ / 1000);

  // Register byte offsets
  localparam logic [7:0] OFS_CTRL   = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_IRQ_ST = 8'h08;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h0C;

  // Control field positions
  localparam int unsigned CTRL_RLY1_LSB  = 0;
  localparam int unsigned CTRL_RLY2_LSB  = 8;
  localparam int unsigned CTRL_EDGE_BIT  = 16;
  localparam int unsigned CTRL_SRC_LSB   = 20;
  localparam int unsigned CTRL_CLR_BIT   = 31;

  // Reset values
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [3:0]  MASK_RESET = 4'h0;

  // Codes
  localparam logic [7:0] RELAY_FN_TORQUE_OFF = 8'h0D;
  localparam logic [7:0] TRIP_CODE_CHANNEL   = 8'h1D;
  localparam logic [7:0] TRIP_CODE_NONE      = 8'h00;

  // Interrupt status bits
  localparam int unsigned IRQ_INHIBIT = 0;
  localparam int unsigned IRQ_RELEASE = 1;
  localparam int unsigned IRQ_FAULT   = 2;
  localparam int unsigned IRQ_START   = 3;

  typedef enum logic [1:0] {DISP_STOP, DISP_RUN, DISP_INHIBIT, DISP_TRIP} sti_disp_type;

  // Control register fields
  typedef struct packed {
    logic [3:0] start_source_select;
    logic       start_mode_select;
    logic [7:0] relay_two_function_select;
    logic [7:0] relay_one_function_select;
  } sti_ctrl_type;

  // Drive-facing outputs
  typedef struct packed {
    logic         run_enable;
    logic         relay_one_closed;
    logic         relay_two_closed;
    logic         healthy;
    sti_disp_type disp;
    logic [7:0]   trip_code;
  } sti_out_type;

endpackage : sti_pkg

/* File: test/sti_interlock_asserts.sv */
// Port checks for the torque-off interlock
module sti_chk
  import sti_pkg::*;
(
  // Clock and reset
  input wire logic        hclk,
  input wire logic        hresetn,
  // Channels and gating
  input wire logic        torque_ch_a,
  input wire logic        torque_ch_b,
  input wire logic        pwm_gate_req,
  input wire logic        pwm_gate,
  // Drive status
  input wire sti_out_type drv_out
);
  localparam int FAULT_AT = DISAGREE_CYC + 4;
  int dis_cnt;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  // Cycles of channel disagreement at the pins
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      dis_cnt <= 0;
    else if (torque_ch_a == torque_ch_b)
      dis_cnt <= 0;
    else if (dis_cnt < FAULT_AT)
      dis_cnt <= dis_cnt + 1;
  end
  gate_off_a: assert property (!(torque_ch_a && torque_ch_b) |-> !pwm_gate)
    else $error("gate on while de-energised");
  gate_cond_a: assert property (pwm_gate |-> pwm_gate_req ##1 drv_out.run_enable)
    else $error("gate without run");
  inhibit_show_a: assert property ((!torque_ch_a && !torque_ch_b) [*5]
    |-> drv_out.disp inside {DISP_INHIBIT, DISP_TRIP}) else $error("no inhibit shown");
  no_run_a: assert property (!torque_ch_a [*5] |-> !drv_out.run_enable)
    else $error("run while de-energised");
  standby_a: assert property ((torque_ch_a && torque_ch_b) [*5] ##0
    drv_out.trip_code == TRIP_CODE_NONE |-> drv_out.disp != DISP_INHIBIT)
    else $error("inhibit while energised");
  trip_shown_a: assert property (drv_out.trip_code != TRIP_CODE_NONE
    |-> drv_out.disp == DISP_TRIP && !drv_out.healthy) else $error("trip not shown");
  trip_code_a: assert property (drv_out.disp == DISP_TRIP
    |-> drv_out.trip_code == 8'h1D) else $error("wrong trip code");
  fault_time_a: assert property (dis_cnt == FAULT_AT |-> drv_out.disp == DISP_TRIP)
    else $error("fault not reported");
  cover property (drv_out.disp == DISP_TRIP);
  cover property ($fell(pwm_gate));
  cover property (drv_out.run_enable);
endmodule : sti_chk

bind sti_interlock sti_chk i_chk (.hclk(hclk), .hresetn(hresetn), .torque_ch_a(torque_ch_a),
  .torque_ch_b(torque_ch_b), .pwm_gate_req(pwm_gate_req), .pwm_gate(pwm_gate),
  .drv_out(drv_out));

/* File: test/sti_safety_relay.sv */
// Behavioural safety relay feeding the two torque-off channels
module sti_safety_relay
(
  // Bench commands
  input  wire logic energise,
  input  wire logic weld_b,
  // Contacts, high when energised
  output logic      ch_a,
  output logic      ch_b
);
  timeunit 1ns;
  timeprecision 1ns;
  // A welded contact keeps channel b energised
  assign ch_a = energise;
  assign ch_b = energise | weld_b;
endmodule : sti_safety_relay

/* File: test/sti_interlock_tb_top.sv */
// Self-checking bench for the torque-off interlock
module sti_interlock_tb_top
  import sti_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        hclk, hresetn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic        energise, weld_b, ch_a, ch_b, pwm_gate_req, pwm_gate;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic [3:0]  run_cmd;
  logic [31:0] haddr, hwdata, hrdata, rd;
  sti_out_type drv_out;
  int          errors, num_checks;
  assign hready = hreadyout;
  sti_interlock i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .torque_ch_a(ch_a),
    .torque_ch_b(ch_b), .run_cmd(run_cmd), .pwm_gate_req(pwm_gate_req),
    .pwm_gate(pwm_gate), .drv_out(drv_out), .irq(irq));
  sti_safety_relay i_relay (.energise(energise), .weld_b(weld_b), .ch_a(ch_a), .ch_b(ch_b));
  initial
  begin
    hclk = 1'b0;
    forever #25 hclk = ~hclk;
  end
  task summarize();
    $display("errors=%0d num_checks=%0d", errors, num_checks);
    if (errors == 0 && num_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR %0t %s", $time, msg);
    end
  endtask : chk
  task idle(input int n);
    repeat (n) @(posedge hclk);
  endtask : idle
  task rdy();
    int n;
    n = 0;
    do
    begin
      @(posedge hclk);
      n++;
    end
    while (hready !== 1'b1 && n < 50);
    if (hready !== 1'b1)
    begin
      errors++;
      summarize();
    end
  endtask : rdy
  task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= {24'h0, a};
    hwrite <= wr;
    htrans <= 2'h2;
    rdy();
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
    rd = hrdata;
    hsel <= 1'b0;
  endtask : bus
  task wirq(input logic [7:0] a, input logic [31:0] d, input logic e);
    bus(1'b1, a, d);
    idle(2);
    chk(irq, e, "irq level");
  endtask : wirq
  task s_inhibit();
    bus(1'b0, OFS_CTRL, '0);
    chk(rd, CTRL_RESET, "ctrl reset");
    bus(1'b0, 8'h40, '0);
    chk(rd, '0, "unmapped read");
    chk(hresp, 1'b0, "error response");
    run_cmd      <= 4'h1;
    pwm_gate_req <= 1'b1;
    bus(1'b1, OFS_CTRL, 32'h0000_000D);
    idle(5);
    chk(drv_out.disp, DISP_INHIBIT, "no inhibit");
    chk(drv_out.run_enable | pwm_gate, 1'b0, "start taken");
    chk({drv_out.relay_one_closed, drv_out.relay_two_closed}, 2'b01, "relay one");
    bus(1'b1, OFS_CTRL, 32'h0000_0D00);
    idle(2);
    chk({drv_out.relay_one_closed, drv_out.relay_two_closed}, 2'b10, "relay two");
  endtask : s_inhibit
  task s_run();
    bus(1'b1, OFS_CTRL, 32'h0000_0D0D);
    bus(1'b1, OFS_IRQ_ST, 32'hF);
    bus(1'b1, OFS_IRQ_MSK, 32'h1);
    energise <= 1'b1;
    idle(6);
    chk(drv_out.run_enable & pwm_gate & drv_out.healthy, 1'b1, "no start");
    chk({drv_out.relay_one_closed, drv_out.relay_two_closed}, 2'b11, "relays open");
    chk(irq, 1'b0, "irq early");
    bus(1'b0, OFS_IRQ_ST, '0);
    chk(rd, 32'h0000_000A, "release and start events");
    energise <= 1'b0;
    idle(1);
    chk(pwm_gate, 1'b0, "gate held");
    idle(3);
    chk(drv_out.disp, DISP_INHIBIT, "late inhibit");
    chk(irq, 1'b1, "no irq");
    wirq(OFS_IRQ_MSK, 32'h0, 1'b0);
    wirq(OFS_IRQ_MSK, 32'h1, 1'b1);
    wirq(OFS_IRQ_ST, 32'h1, 1'b0);
  endtask : s_run
  task s_edge();
    bus(1'b1, OFS_CTRL, 32'h0011_0D0D);
    run_cmd <= 4'h2;
    idle(2);
    energise <= 1'b1;
    idle(8);
    chk(drv_out.run_enable, 1'b0, "level start");
    run_cmd <= 4'h0;
    idle(4);
    run_cmd <= 4'h3;
    idle(6);
    chk(drv_out.run_enable, 1'b1, "no edge start");
    run_cmd <= 4'h1;
    idle(5);
    chk(drv_out.run_enable, 1'b0, "wrong source");
  endtask : s_edge
  task s_fault();
    bus(1'b1, OFS_IRQ_MSK, 32'h4);
    weld_b   <= 1'b1;
    energise <= 1'b0;
    idle(DISAGREE_CYC - 10);
    chk(drv_out.disp, DISP_INHIBIT, "early trip");
    idle(20);
    chk(drv_out.disp, DISP_TRIP, "trip hidden");
    chk({drv_out.healthy, irq}, 2'b01, "fault health");
    bus(1'b0, OFS_STATUS, '0);
    chk(rd[15:8], 8'h1D, "trip code");
    weld_b   <= 1'b0;
    energise <= 1'b1;
    // Let the channels agree through the synchroniser, else the set beats the clear
    idle(4);
    bus(1'b1, OFS_CTRL, 32'h8011_0D0D);
    idle(4);
    chk({drv_out.healthy, drv_out.trip_code}, 9'h100, "fault stuck");
  endtask : s_fault
  initial
  begin
    {hsel, hwrite, hresetn, energise, weld_b, pwm_gate_req} = '0;
    htrans     = '0;
    hsize      = 3'h2;
    haddr      = '0;
    hwdata     = '0;
    run_cmd    = '0;
    errors     = 0;
    num_checks = 0;
    repeat (20) @(posedge hclk);
    hresetn <= 1'b1;
    s_inhibit();
    s_run();
    s_edge();
    s_fault();
    summarize();
  end
endmodule : sti_interlock_tb_top
